// ### common/ppa_pkg.sv
// Purpose: Shared constants and types for the primary bus arbiter block
// Assumes: 32-bit APB, byte addresses, 200 MHz primary bus clock
// Notes: Offsets are byte addresses of aligned words
package ppa_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] OFF_MISC_CTRL = 12'h0160;
  localparam logic [11:0] OFF_ARB_CTRL = 12'h0164;
  localparam logic [11:0] OFF_EXTRA_ASSIGN = 12'h0168;
  localparam logic [11:0] OFF_ARB_STATUS = 12'h016C;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h0170;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h0174;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h0178;
  localparam logic [11:0] OFF_IMAGE_BASE = 12'h017C;

  // ==========================================================
  // Field positions
  localparam int MISC_BAR_EN_BIT = 15;
  localparam int MISC_RETRY_LSB = 8;
  localparam int MISC_ABORT_MAP_BIT = 7;
  localparam int ARB_FLAG_LSB = 16;
  localparam int ARB_PRI_LSB = 8;
  localparam int ARB_WATCH_EN_BIT = 4;
  localparam int ARB_PARK_BIT = 3;
  localparam int ARB_PARK_SEL_LSB = 0;
  localparam int STAT_ARB_ON_BIT = 0;
  localparam int STAT_OWNER_LSB = 8;
  localparam int IRQ_UNRESP_BIT = 0;
  localparam int IRQ_RETRY_BIT = 1;

  // ==========================================================
  // Write masks and values after reset
  localparam logic [31:0] MISC_WR_MASK = 32'h0000_8F80;
  localparam logic [31:0] MISC_RESET = 32'h0000_8080;
  localparam logic [31:0] ARB_WR_MASK = 32'h00FF_FF1F;
  localparam logic [31:0] ARB_RESET = 32'h0000_0000;
  localparam logic [31:0] IMAGE_BASE_MASK = 32'hFFFF_F000;
  localparam logic [2:0] EXTRA_ASSIGN_RESET = 3'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ==========================================================
  // Counts
  localparam logic [4:0] WATCH_LIMIT = 5'h10;
  localparam logic [3:0] RETRY_CODE_FOREVER = 4'h0;
  localparam logic [3:0] RETRY_CODE_SHORT = 4'h1;
  localparam logic [24:0] RETRY_SHORT_COUNT = 25'h000_0040;
  localparam logic [24:0] RETRY_LONG_COUNT = 25'h100_0000;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_PARK,
    ST_GRANT,
    ST_BUSY
  } ppa_state_type;

endpackage

// ### src/ppa_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to CLK
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ppa_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (ce) begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule
`default_nettype wire

// ### src/ppa_watch.sv
// Purpose: Grant-to-transaction watch counter
// Assumes: One granted master at a time
// Notes: Expiry is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module ppa_watch (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic start,
  input wire logic stop,
  output logic expired
);

  logic running_q;
  logic [4:0] cnt_q;
  logic expired_q;
  logic last_tick;

  assign last_tick = running_q && !stop && (cnt_q == ppa_pkg::WATCH_LIMIT - 5'h01);

  always_ff @(posedge clk) begin
    if (rst) begin
      running_q <= 1'b0;
      cnt_q <= 5'h00;
      expired_q <= 1'b0;
    end else if (ce) begin
      expired_q <= last_tick;
      if (start) begin
        running_q <= enable;
        cnt_q <= 5'h00;
      end else if (stop || last_tick || !enable) begin
        running_q <= 1'b0;
      end else if (running_q) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  assign expired = expired_q;

endmodule
`default_nettype wire

// ### src/ppa_top.sv
// Purpose: Primary bus arbiter and misc control with APB registers
// Assumes: REQ/GNT/FRAME/IRDY pins are active low and asynchronous
// Notes: Master 0 is the bridge itself, 1 to 7 are external
//
// How it works
// - Four fixed external masters, three more enabled by extra-assign bits.
// - Strap enables arbiter; when off bridge requests over the external pair.
// - Status register reports whether the arbiter is enabled.
// - One unresponsive flag per master, set after 16 clocks without response.
// - Flagged masters are excluded from arbitration; cleared flags are included.
// - Each external master priority bit selects high or low level.
// - Bridge priority bit selects high or low level.
// - Park on selected master when park bit set, else last granted.
// - Park code 0 is the bridge, codes 1 to 7 external masters.
// - Retry code 0 forever, 1 is 64, other codes 2^24 retries.
// - Config master-abort returns all ones when bit set, else target-abort.
// - Reaching the retry limit raises a loggable error event.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ppa_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ARB_STRAP,
  input wire logic [7:1] MASTER_REQ_N,
  output logic [7:1] MASTER_GNT_N,
  input wire logic FRAME_N,
  input wire logic IRDY_N,
  input wire logic BRIDGE_REQ,
  output logic BRIDGE_GNT,
  output logic EXT_ARB_REQUEST_LINE_N,
  input wire logic EXT_ARB_GRANT_LINE_N,
  input wire logic RETRY_EVENT,
  input wire logic XFER_DONE,
  output logic MAX_RETRY_ERR,
  output logic REG_IMAGE_ENABLE,
  output logic [31:0] REG_IMAGE_BASE,
  output logic CFG_ABORT_ALL_ONES,
  output logic IRQ
);

  // ==========================================================
  // Pin synchronisers
  logic [10:0] pins_s;
  logic [7:1] req_n_s;
  logic frame_n_s;
  logic irdy_n_s;
  logic ext_gnt_n_s;
  logic strap_s;

  ppa_sync #(
    .WIDTH(11),
    .RST_VAL(11'h7FE)
  ) u_sync (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .din({MASTER_REQ_N, FRAME_N, IRDY_N, EXT_ARB_GRANT_LINE_N, ARB_STRAP}),
    .dout(pins_s)
  );

  assign req_n_s = pins_s[10:4];
  assign frame_n_s = pins_s[3];
  assign irdy_n_s = pins_s[2];
  assign ext_gnt_n_s = pins_s[1];
  assign strap_s = pins_s[0];

  // ==========================================================
  // Registers
  logic [31:0] misc_q;
  logic [31:0] arb_q;
  logic [2:0] extra_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic [31:0] image_base_q;
  logic [7:0] flags_q;
  logic primary_arbiter_on_q;
  logic [1:0] settle_q;
  logic strap_done_q;

  // ==========================================================
  // APB decode
  logic access;
  logic apb_done;
  logic wr_en;
  logic [11:0] addr_w;
  logic hit_misc;
  logic hit_arb;
  logic hit_extra;
  logic hit_stat;
  logic hit_istat;
  logic hit_iclr;
  logic hit_ien;
  logic hit_base;
  logic mapped;
  logic [31:0] rd_mux;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  assign addr_w = {PADDR[11:2], 2'b00};
  assign access = PSEL && PENABLE;
  assign apb_done = access && pready_q;
  assign wr_en = apb_done && PWRITE;
  assign hit_misc = (addr_w == ppa_pkg::OFF_MISC_CTRL);
  assign hit_arb = (addr_w == ppa_pkg::OFF_ARB_CTRL);
  assign hit_extra = (addr_w == ppa_pkg::OFF_EXTRA_ASSIGN);
  assign hit_stat = (addr_w == ppa_pkg::OFF_ARB_STATUS);
  assign hit_istat = (addr_w == ppa_pkg::OFF_IRQ_STATUS);
  assign hit_iclr = (addr_w == ppa_pkg::OFF_IRQ_CLEAR);
  assign hit_ien = (addr_w == ppa_pkg::OFF_IRQ_ENABLE);
  assign hit_base = (addr_w == ppa_pkg::OFF_IMAGE_BASE);
  assign mapped = hit_misc | hit_arb | hit_extra | hit_stat | hit_istat | hit_iclr
                  | hit_ien | hit_base;

  // ==========================================================
  // Control fields
  logic bar_en;
  logic [3:0] retry_code;
  logic [7:0] pri_vec;
  logic watch_en;
  logic park_sel;
  logic [2:0] park_code_sel;
  logic [7:0] present;

  assign bar_en = misc_q[ppa_pkg::MISC_BAR_EN_BIT];
  assign retry_code = misc_q[ppa_pkg::MISC_RETRY_LSB +: 4];
  assign pri_vec = arb_q[ppa_pkg::ARB_PRI_LSB +: 8];
  assign watch_en = arb_q[ppa_pkg::ARB_WATCH_EN_BIT];
  assign park_sel = arb_q[ppa_pkg::ARB_PARK_BIT];
  assign park_code_sel = arb_q[ppa_pkg::ARB_PARK_SEL_LSB +: 3];
  assign present = {extra_q, 5'h1F};

  // ==========================================================
  // Arbitration
  ppa_pkg::ppa_state_type state_q;
  ppa_pkg::ppa_state_type state_d;
  logic [7:0] gnt_q;
  logic [7:0] gnt_d;
  logic [2:0] owner_q;
  logic [2:0] owner_d;
  logic [2:0] last_q;
  logic [2:0] last_d;
  logic [7:0] req_vec;
  logic [7:0] elig;
  logic [7:0] hi;
  logic [7:0] pool;
  logic [2:0] winner;
  logic [2:0] park_code;
  logic park_ok;
  logic bus_idle;
  logic others;
  logic watch_start;
  logic watch_stop;
  logic expired;
  logic [7:0] flag_set;

  function automatic logic [2:0] rr_pick(input logic [7:0] m, input logic [2:0] last);
    logic [2:0] idx;
    logic [2:0] pick;
    pick = last;
    for (int i = 8; i >= 1; i--) begin
      idx = last + i[2:0];
      if (m[idx]) begin
        pick = idx;
      end
    end
    return pick;
  endfunction

  assign req_vec = {~req_n_s, BRIDGE_REQ};
  assign elig = req_vec & present & ~flags_q;
  assign hi = elig & pri_vec;
  assign pool = (|hi) ? hi : elig;
  assign winner = rr_pick(pool, last_q);
  assign park_code = park_sel ? park_code_sel : last_q;
  assign park_ok = present[park_code] && !flags_q[park_code];
  assign bus_idle = frame_n_s && irdy_n_s;
  assign others = |(elig & ~(8'h01 << owner_q));
  assign watch_start = (state_q == ppa_pkg::ST_PARK) && (state_d == ppa_pkg::ST_GRANT);
  // Any exit from grant stops the watch, so a withdrawn request is never flagged
  assign watch_stop = (state_q == ppa_pkg::ST_GRANT) && (state_d != ppa_pkg::ST_GRANT);
  assign flag_set = expired ? (8'h01 << owner_q) : 8'h00;

  always_comb begin
    state_d = state_q;
    gnt_d = gnt_q;
    owner_d = owner_q;
    last_d = last_q;
    case (state_q)
      ppa_pkg::ST_PARK: begin
        if ((|elig) && bus_idle) begin
          gnt_d = 8'h01 << winner;
          owner_d = winner;
          last_d = winner;
          state_d = ppa_pkg::ST_GRANT;
        end else if (bus_idle) begin
          gnt_d = park_ok ? (8'h01 << park_code) : 8'h00;
        end
      end
      ppa_pkg::ST_GRANT: begin
        if (!frame_n_s) begin
          state_d = ppa_pkg::ST_BUSY;
        end else if (expired || !req_vec[owner_q]) begin
          gnt_d = 8'h00;
          state_d = ppa_pkg::ST_PARK;
        end
      end
      ppa_pkg::ST_BUSY: begin
        if (!req_vec[owner_q] || others) begin
          gnt_d = 8'h00;
        end
        if ((gnt_q == 8'h00) && bus_idle) begin
          state_d = ppa_pkg::ST_PARK;
        end
      end
      default: begin
        gnt_d = 8'h00;
        state_d = ppa_pkg::ST_PARK;
      end
    endcase
    if (!primary_arbiter_on_q) begin
      gnt_d = 8'h00;
      state_d = ppa_pkg::ST_PARK;
    end
  end

  ppa_watch u_watch (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .enable(watch_en),
    .start(watch_start),
    .stop(watch_stop),
    .expired(expired)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= ppa_pkg::ST_PARK;
      gnt_q <= 8'h00;
      owner_q <= 3'h0;
      last_q <= 3'h0;
    end else if (CE) begin
      state_q <= state_d;
      gnt_q <= gnt_d;
      owner_q <= owner_d;
      last_q <= last_d;
    end
  end

  // ==========================================================
  // Strap capture after reset release
  always_ff @(posedge CLK) begin
    if (RST) begin
      settle_q <= 2'h0;
      strap_done_q <= 1'b0;
      primary_arbiter_on_q <= 1'b0;
    end else if (CE && !strap_done_q) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == ppa_pkg::STRAP_SETTLE) begin
        strap_done_q <= 1'b1;
        primary_arbiter_on_q <= strap_s;
      end
    end
  end

  // ==========================================================
  // Retry limit
  logic [24:0] retry_limit;
  logic [24:0] retry_cnt_q;
  logic retry_hit;
  logic max_err_q;

  assign retry_limit = (retry_code == ppa_pkg::RETRY_CODE_FOREVER) ? 25'h000_0000 :
                       (retry_code == ppa_pkg::RETRY_CODE_SHORT) ? ppa_pkg::RETRY_SHORT_COUNT :
                       ppa_pkg::RETRY_LONG_COUNT;
  assign retry_hit = RETRY_EVENT && (retry_limit != 25'h000_0000)
                     && (retry_cnt_q + 25'h000_0001 == retry_limit);

  always_ff @(posedge CLK) begin
    if (RST) begin
      retry_cnt_q <= 25'h000_0000;
      max_err_q <= 1'b0;
    end else if (CE) begin
      max_err_q <= retry_hit;
      if (XFER_DONE || retry_hit) begin
        retry_cnt_q <= 25'h000_0000;
      end else if (RETRY_EVENT) begin
        retry_cnt_q <= retry_cnt_q + 25'h000_0001;
      end
    end
  end

  // ==========================================================
  // Register writes
  logic [1:0] irq_evt;

  assign irq_evt = {retry_hit, |flag_set};

  always_ff @(posedge CLK) begin
    if (RST) begin
      misc_q <= ppa_pkg::MISC_RESET;
      arb_q <= ppa_pkg::ARB_RESET;
      extra_q <= ppa_pkg::EXTRA_ASSIGN_RESET;
      irq_en_q <= ppa_pkg::IRQ_RESET;
      image_base_q <= 32'h0000_0000;
    end else if (CE) begin
      if (wr_en && hit_misc) begin
        misc_q <= PWDATA & ppa_pkg::MISC_WR_MASK;
      end
      if (wr_en && hit_arb) begin
        arb_q <= PWDATA & ppa_pkg::ARB_WR_MASK;
      end
      if (wr_en && hit_extra) begin
        extra_q <= PWDATA[2:0];
      end
      if (wr_en && hit_ien) begin
        irq_en_q <= PWDATA[1:0];
      end
      if (wr_en && hit_base && bar_en) begin
        image_base_q <= PWDATA & ppa_pkg::IMAGE_BASE_MASK;
      end
    end
  end

  // Hardware set wins over a software write or clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      flags_q <= 8'h00;
      irq_stat_q <= ppa_pkg::IRQ_RESET;
    end else if (CE) begin
      flags_q <= ((wr_en && hit_arb) ? PWDATA[ppa_pkg::ARB_FLAG_LSB +: 8] : flags_q)
                 | flag_set;
      irq_stat_q <= (irq_stat_q & ~((wr_en && hit_iclr) ? PWDATA[1:0] : 2'h0)) | irq_evt;
    end
  end

  // ==========================================================
  // Read mux and APB answer
  assign rd_mux = hit_misc ? misc_q :
                  hit_arb ? (arb_q | {8'h00, flags_q, 16'h0000}) :
                  hit_extra ? {29'h0000_0000, extra_q} :
                  hit_stat ? {21'h00_0000, owner_q, 7'h00, primary_arbiter_on_q} :
                  hit_istat ? {30'h0000_0000, irq_stat_q} :
                  hit_ien ? {30'h0000_0000, irq_en_q} :
                  (hit_base && bar_en) ? image_base_q :
                  32'h0000_0000;

  always_ff @(posedge CLK) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (CE) begin
      pready_q <= access && !pready_q;
      pslverr_q <= access && !pready_q && !mapped;
      if (access && !pready_q && !PWRITE) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Outputs
  logic [7:1] gnt_n_q;
  logic bridge_gnt_q;
  logic ext_req_n_q;
  logic irq_q;

  always_ff @(posedge CLK) begin
    if (RST) begin
      gnt_n_q <= 7'h7F;
      bridge_gnt_q <= 1'b0;
      ext_req_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else if (CE) begin
      gnt_n_q <= ~gnt_d[7:1];
      bridge_gnt_q <= primary_arbiter_on_q ? gnt_d[0] : !ext_gnt_n_s;
      ext_req_n_q <= !(BRIDGE_REQ && !primary_arbiter_on_q);
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign MASTER_GNT_N = gnt_n_q;
  assign BRIDGE_GNT = bridge_gnt_q;
  assign EXT_ARB_REQUEST_LINE_N = ext_req_n_q;
  assign MAX_RETRY_ERR = max_err_q;
  assign REG_IMAGE_ENABLE = bar_en;
  assign REG_IMAGE_BASE = image_base_q;
  assign CFG_ABORT_ALL_ONES = misc_q[ppa_pkg::MISC_ABORT_MAP_BIT];
  assign IRQ = irq_q;

endmodule
`default_nettype wire

// ### verification/ppa_chk.sv
// Purpose: Port assertions for ppa_top
// Assumes: Register outputs follow their bits one edge after the APB write
// Notes: Bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module ppa_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic ARB_STRAP,
  input wire logic [7:1] MASTER_GNT_N,
  input wire logic BRIDGE_GNT,
  input wire logic RETRY_EVENT,
  input wire logic MAX_RETRY_ERR,
  input wire logic REG_IMAGE_ENABLE,
  input wire logic [31:0] REG_IMAGE_BASE,
  input wire logic CFG_ABORT_ALL_ONES,
  input wire logic IRQ
);
  // ====================
  // Completed APB accesses
  wire done = PSEL && PENABLE && PREADY;
  wire wr_misc = done && PWRITE && (PADDR == ppa_pkg::OFF_MISC_CTRL);
  wire wr_base = done && PWRITE && (PADDR == ppa_pkg::OFF_IMAGE_BASE);
  wire rd_base = done && !PWRITE && (PADDR == ppa_pkg::OFF_IMAGE_BASE);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ====================
  // Assertions
  a_grant_single: assert property ($onehot0({~MASTER_GNT_N, BRIDGE_GNT}))
    else $error("more than one grant active");
  a_arb_off: assert property (!ARB_STRAP [*8] |-> &MASTER_GNT_N)
    else $error("grant given with arbiter strapped off");
  a_base_hidden: assert property (rd_base && !REG_IMAGE_ENABLE |-> PRDATA == 32'h0000_0000)
    else $error("hidden image base read not zero");
  a_base_frozen: assert property (wr_base && !REG_IMAGE_ENABLE |=> $stable(REG_IMAGE_BASE))
    else $error("hidden image base took a write");
  a_bar_follow: assert property (wr_misc |=> REG_IMAGE_ENABLE == $past(PWDATA[15]))
    else $error("image enable does not follow its bit");
  a_map_follow: assert property (wr_misc |=> CFG_ABORT_ALL_ONES == $past(PWDATA[7]))
    else $error("abort mapping does not follow its bit");
  a_reset_map: assert property ($fell(RST) |-> CFG_ABORT_ALL_ONES && REG_IMAGE_ENABLE)
    else $error("mapping or image enable not set after reset");
  a_retry_cause: assert property (MAX_RETRY_ERR |-> $past(RETRY_EVENT) || $past(RETRY_EVENT, 2))
    else $error("retry limit error without a retry");
  a_retry_pulse: assert property (MAX_RETRY_ERR |=> !MAX_RETRY_ERR)
    else $error("retry limit error longer than one cycle");
  c_grant: cover property (!MASTER_GNT_N[2] ##1 !MASTER_GNT_N[2]);
  c_retry: cover property (MAX_RETRY_ERR);
  c_irq: cover property ($rose(IRQ));
endmodule
bind ppa_top ppa_chk chk_u (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .ARB_STRAP(ARB_STRAP), .MASTER_GNT_N(MASTER_GNT_N), .BRIDGE_GNT(BRIDGE_GNT),
  .RETRY_EVENT(RETRY_EVENT), .MAX_RETRY_ERR(MAX_RETRY_ERR), .REG_IMAGE_ENABLE(REG_IMAGE_ENABLE),
  .REG_IMAGE_BASE(REG_IMAGE_BASE), .CFG_ABORT_ALL_ONES(CFG_ABORT_ALL_ONES), .IRQ(IRQ));
`default_nettype wire

// ### verification/ppa_masters.sv
// Purpose: External bus masters on the request and grant pairs
// Assumes: One short transaction per grant, lines pulled up when idle
// Notes: A muted master never answers its grant
`timescale 1ns/1ps
`default_nettype none
module ppa_masters (
  input wire logic clk,
  input wire logic [7:1] want,
  input wire logic [7:1] mute,
  input wire logic [7:1] gnt_n,
  output logic [7:1] req_n,
  output logic frame_n,
  output logic irdy_n
);
  logic [2:0] bcnt_q = 3'h0;
  logic [7:1] hold_q = 7'h00;
  // ====================
  // Request drops during and just after own transaction
  assign req_n = ~(want & ~hold_q);
  assign frame_n = !(bcnt_q > 3'h4);
  assign irdy_n = !(bcnt_q > 3'h3);
  always @(posedge clk) begin
    if (bcnt_q != 3'h0) begin
      bcnt_q <= bcnt_q - 3'h1;
    end else begin
      hold_q <= 7'h00;
      for (int i = 1; i < 8; i++) begin
        if (!gnt_n[i] && want[i] && !mute[i]) begin
          bcnt_q <= 3'h6;
          hold_q[i] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: Self-checking bench for ppa_top
// Assumes: Partner masters answer grants on the shared bus
// Notes: Table rows hold register access cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAIT(c, l) for (n = 0; n < (l) && !(c); n++) @(posedge clk);
module tb_top;
  typedef struct {logic [11:0] a; logic [31:0] w, r0, r1; logic er;} ppa_row_type;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, strap = 1'b1;
  logic breq = 1'b0, egnt_n = 1'b1, rev = 1'b0, xdone = 1'b0, e, prdy, perr, bgnt;
  logic ereq_n, mre, ien, amap, irq, frame_n, irdy_n;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, q, prd, ibase;
  logic [7:1] want = 7'h00, mute = 7'h00, gnt_n, req_n, gp = 7'h7F;
  int bad_count = 0, total_checks = 0, n, rp = 0, rp0;
  int cnt[8] = '{default: 0};
  int c0[8];
  // Extra masters assigned before any park code names them
  ppa_row_type rows[7] = '{
    '{ppa_pkg::OFF_MISC_CTRL, 32'hFFFF_FFFF, 32'h0000_8080, 32'h0000_8F80, 1'b0},
    '{ppa_pkg::OFF_EXTRA_ASSIGN, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0007, 1'b0},
    '{ppa_pkg::OFF_ARB_CTRL, 32'h0000_FF1F, 32'h0000_0000, 32'h0000_FF1F, 1'b0},
    '{ppa_pkg::OFF_IMAGE_BASE, 32'hABCD_E123, 32'h0000_0000, 32'hABCD_E000, 1'b0},
    '{ppa_pkg::OFF_IRQ_STATUS, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{ppa_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0003, 1'b0},
    '{12'h1F0, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 1'b1}};
  ppa_masters pm_u (.clk(clk), .want(want), .mute(mute), .gnt_n(gnt_n), .req_n(req_n),
    .frame_n(frame_n), .irdy_n(irdy_n));
  ppa_top dut_u (.CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .ARB_STRAP(strap), .MASTER_REQ_N(req_n), .MASTER_GNT_N(gnt_n), .FRAME_N(frame_n),
    .IRDY_N(irdy_n), .BRIDGE_REQ(breq), .BRIDGE_GNT(bgnt), .EXT_ARB_REQUEST_LINE_N(ereq_n),
    .EXT_ARB_GRANT_LINE_N(egnt_n), .RETRY_EVENT(rev), .XFER_DONE(xdone),
    .MAX_RETRY_ERR(mre), .REG_IMAGE_ENABLE(ien), .REG_IMAGE_BASE(ibase),
    .CFG_ABORT_ALL_ONES(amap), .IRQ(irq));
  initial forever #2.5 clk = ~clk;
  // ====================
  // Grant and retry error counters
  always @(posedge clk) begin
    if (mre === 1'b1) rp <= rp + 1;
    for (int i = 1; i < 8; i++) if (gp[i] === 1'b1 && gnt_n[i] === 1'b0) cnt[i] <= cnt[i] + 1;
    gp <= gnt_n;
  end
  // ====================
  // Bus tasks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (prdy !== 1'b1 && k < 20);
    if (k >= 20) bad_count++;
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic arb(input logic [31:0] v);
    apb(1'b1, ppa_pkg::OFF_ARB_CTRL, v);
  endtask
  task automatic retry(input int k);
    repeat (k) begin
      @(posedge clk);
      rev <= 1'b1;
      @(posedge clk);
      rev <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  // ====================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    rd(ppa_pkg::OFF_ARB_STATUS);
    `CHK(q[0], 1'b1)
    foreach (rows[i]) begin
      rd(rows[i].a);
      `CHK(q, rows[i].r0)
      apb(1'b1, rows[i].a, rows[i].w);
      `CHK(e, rows[i].er)
      rd(rows[i].a);
      `CHK(q, rows[i].r1)
    end
    arb(32'h0000_0010);
    c0 = cnt;
    want <= 7'h07;
    repeat (300) @(posedge clk);
    `CHK(cnt[1] > c0[1] && cnt[2] > c0[2] && cnt[3] > c0[3], 1'b1)
    `CHK((cnt[1] - c0[1]) - (cnt[3] - c0[3]) inside {[-2:2]}, 1'b1)
    arb(32'h0000_0810);
    c0 = cnt;
    repeat (300) @(posedge clk);
    `CHK(cnt[3] - c0[3] > cnt[1] - c0[1], 1'b1)
    arb(32'h0000_0100);
    breq <= 1'b1;
    `WAIT(bgnt === 1'b1, 60)
    `CHK(bgnt, 1'b1)
    breq <= 1'b0;
    want <= 7'h02;
    mute <= 7'h02;
    arb(32'h0000_0008);
    repeat (60) @(posedge clk);
    rd(ppa_pkg::OFF_ARB_CTRL);
    `CHK(q[18], 1'b0)
    want <= 7'h00;
    arb(32'h0000_0018);
    want <= 7'h02;
    `WAIT(irq === 1'b1, 100)
    `CHK(irq, 1'b1)
    rd(ppa_pkg::OFF_ARB_CTRL);
    `CHK(q[18], 1'b1)
    c0 = cnt;
    repeat (60) @(posedge clk);
    `CHK(cnt[2] - c0[2], 0)
    apb(1'b1, ppa_pkg::OFF_IRQ_ENABLE, 32'h0000_0002);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, ppa_pkg::OFF_IRQ_CLEAR, 32'h0000_0001);
    rd(ppa_pkg::OFF_IRQ_STATUS);
    `CHK(q[0], 1'b0)
    mute <= 7'h00;
    arb(32'h0000_0018);
    `WAIT(gnt_n[2] === 1'b0, 60)
    `CHK(gnt_n[2], 1'b0)
    want <= 7'h00;
    for (int c = 0; c < 8; c++) begin
      arb(32'h0000_0008 | c);
      repeat (12) @(posedge clk);
      `CHK({gnt_n, ~bgnt}, ~(8'h01 << c))
      rd(ppa_pkg::OFF_ARB_STATUS);
      `CHK(q[10:8], 3'h2)
    end
    arb(32'h0000_0000);
    want <= 7'h10;
    `WAIT(gnt_n[5] === 1'b0, 60)
    want <= 7'h00;
    repeat (30) @(posedge clk);
    `CHK(gnt_n, 7'h6F)
    apb(1'b1, ppa_pkg::OFF_EXTRA_ASSIGN, 32'h0000_0000);
    arb(32'h0000_0008);
    want <= 7'h40;
    repeat (60) @(posedge clk);
    `CHK(gnt_n[7], 1'b1)
    want <= 7'h00;
    apb(1'b1, ppa_pkg::OFF_MISC_CTRL, 32'h0000_8180);
    rp0 = rp;
    retry(63);
    `CHK(rp - rp0, 0)
    retry(1);
    `CHK(rp - rp0, 1)
    rd(ppa_pkg::OFF_IRQ_STATUS);
    `CHK(q[1], 1'b1)
    retry(40);
    xdone <= 1'b1;
    @(posedge clk);
    xdone <= 1'b0;
    retry(40);
    `CHK(rp - rp0, 1)
    for (int c = 0; c < 3; c += 2) begin
      apb(1'b1, ppa_pkg::OFF_MISC_CTRL, 32'h0000_8080 | (c << 8));
      retry(70);
      `CHK(rp - rp0, 1)
    end
    apb(1'b1, ppa_pkg::OFF_MISC_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `CHK({ien, amap}, 2'b00)
    apb(1'b1, ppa_pkg::OFF_IMAGE_BASE, 32'h1234_5000);
    rd(ppa_pkg::OFF_IMAGE_BASE);
    `CHK(q, 32'h0000_0000)
    apb(1'b1, ppa_pkg::OFF_MISC_CTRL, 32'h0000_8000);
    rd(ppa_pkg::OFF_IMAGE_BASE);
    `CHK(q, 32'hABCD_E000)
    rst <= 1'b1;
    strap <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK({ien, amap, irq, ibase}, {3'b110, 32'h0000_0000})
    rd(ppa_pkg::OFF_ARB_STATUS);
    `CHK(q[0], 1'b0)
    breq <= 1'b1;
    `WAIT(ereq_n === 1'b0, 10)
    `CHK(ereq_n, 1'b0)
    egnt_n <= 1'b0;
    `WAIT(bgnt === 1'b1, 10)
    `CHK(bgnt, 1'b1)
    want <= 7'h01;
    repeat (20) @(posedge clk);
    `CHK(gnt_n, 7'h7F)
    give_verdict();
  end
endmodule
`default_nettype wire
